/* rtl/fan_led_pkg.sv */
// What this block does
// (R1) Each fan has an 8-bit read-only count of clock ticks per fan pulse.
// (R2) Readable count is last pulse's final count, held until next pulse ends.
// (R3) Reading may be invalid for two pulses after a preload write.
// (R4) Each fan has an 8-bit read/write preload, the count's start value.
// (R5) Writing a preload restarts that fan's running count at once.
// (R6) LED code 01 blinks 0.5 s on, 0.5 s off.
// (R7) LED code 10 blinks 0.5 s on, 1.5 s off.
// (R8) Two LEDs, own 2-bit field; 00 off, 11 on; bits 7:2 reserved.
// (R9) 8-bit read/write scan-code register, bit 0 LSB, bit 7 MSB.
// (R10) Reserved offsets after the scan-code register read zero.
// (R11) Per-fan 2-bit divisor scales count clock; 00 is /4, 11 is /8.
// (R12) On a tach edge, latch count, reload preload, then count ticks.
// (R13) Blink timing comes from a fixed half-second timebase.
`default_nettype none
package fan_led_pkg;
	localparam logic [7:0] REG_TACH1   = 8'h59;
	localparam logic [7:0] REG_TACH2   = 8'h5A;
	localparam logic [7:0] REG_PRE1    = 8'h5B;
	localparam logic [7:0] REG_PRE2    = 8'h5C;
	localparam logic [7:0] REG_IND1    = 8'h5D;
	localparam logic [7:0] REG_IND2    = 8'h5E;
	localparam logic [7:0] REG_SCAN    = 8'h5F;
	localparam logic [7:0] REG_DIV     = 8'h58;
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [7:0] DIV_RESET   = 8'h50;
	localparam int         DIV1_LSB    = 4;
	localparam int         DIV2_LSB    = 6;
	localparam int         ADDR_MSB    = 9;
	localparam int         ADDR_LSB    = 2;
	localparam logic [7:0] IND_FIELD   = 8'h03;
	localparam logic [7:0] COUNT_MAX   = 8'hFF;
	localparam logic [2:0] DIV4_TOP    = 3'h3;
	localparam logic [2:0] DIV8_TOP    = 3'h7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_MHZ      = 250;
	localparam int HALF_SEC_MS  = 500;
	localparam int HALF_SEC_CYC = HALF_SEC_MS * 1000 * CLK_MHZ;
	typedef enum logic [1:0] {
		LED_OFF   = 2'b00,
		LED_FAST  = 2'b01,
		LED_SLOW  = 2'b10,
		LED_ON    = 2'b11
	} led_mode_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;
endpackage : fan_led_pkg
`default_nettype wire

/* rtl/fan_tach_led_runtime.sv */
`timescale 1ns/100ps
`default_nettype none
module fan_tach_led_runtime
	import fan_led_pkg::*;
#(
	parameter int HALF_SEC_TICKS = HALF_SEC_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        fan_channel_one,
	input  wire logic        fan_channel_two,
	output var  logic        indicator_one,
	output var  logic        indicator_two
);
	logic       rst_s1_r;
	logic       rst_s2_r;
	logic       aw_have_r;
	logic       w_have_r;
	logic [7:0] aw_idx_r;
	logic [7:0] wdat_r;
	logic       wstb_r;
	logic [7:0] pre1_r;
	logic [7:0] pre2_r;
	logic [7:0] div_r;
	logic [7:0] ind1_r;
	logic [7:0] ind2_r;
	logic [7:0] scan_r;
	logic [7:0] tach1;
	logic [7:0] tach2;
	logic [31:0] half_cnt_r;
	logic [1:0] phase_r;
	logic       rst_i;

	// Reset synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_i = rst_s2_r;

	// Write path: address and data taken in either order
	wire     aw_take = s_axi_awvalid && s_axi_awready;
	wire     w_take  = s_axi_wvalid && s_axi_wready;
	wire     wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	reg_wr_t wr;
	assign wr = '{addr: aw_idx_r, data: wdat_r};
	wire wr_ok = wr.addr == REG_PRE1 || wr.addr == REG_PRE2
		|| wr.addr == REG_IND1 || wr.addr == REG_IND2
		|| wr.addr == REG_SCAN || wr.addr == REG_DIV;
	wire wr_en   = wr_fire && wstb_r;
	wire pre1_wr = wr_en && wr.addr == REG_PRE1;
	wire pre2_wr = wr_en && wr.addr == REG_PRE2;
	// A preload write restarts from the value being written
	wire [7:0] pre1_val = pre1_wr ? wr.data : pre1_r; // see (R3) (R5)
	wire [7:0] pre2_val = pre2_wr ? wr.data : pre2_r; // see (R3) (R5)

	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_idx_r      <= RESET_BYTE;
			wdat_r        <= RESET_BYTE;
			wstb_r        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_r && !aw_take;
			s_axi_wready  <= !w_have_r && !w_take;
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_idx_r  <= s_axi_awaddr[ADDR_MSB:ADDR_LSB];
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				wdat_r   <= s_axi_wdata[7:0];
				wstb_r   <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software registers
	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			pre1_r <= RESET_BYTE;
			pre2_r <= RESET_BYTE;
			div_r  <= DIV_RESET;
			ind1_r <= RESET_BYTE;
			ind2_r <= RESET_BYTE;
			scan_r <= RESET_BYTE;
		end else if (wr_en) begin
			if (wr.addr == REG_PRE1) pre1_r <= wr.data; // see (R4)
			if (wr.addr == REG_PRE2) pre2_r <= wr.data; // see (R4)
			if (wr.addr == REG_DIV)  div_r  <= wr.data; // see (R11)
			if (wr.addr == REG_IND1) ind1_r <= wr.data & IND_FIELD; // see (R8)
			if (wr.addr == REG_IND2) ind2_r <= wr.data & IND_FIELD; // see (R8)
			if (wr.addr == REG_SCAN) scan_r <= wr.data; // see (R9)
		end
	end

	// Read path; unmapped offsets read zero
	logic [7:0] rd_idx;
	logic [7:0] rd_byte;
	assign rd_idx = s_axi_araddr[ADDR_MSB:ADDR_LSB];
	assign rd_byte =
		rd_idx == REG_TACH1 ? tach1 : // see (R1) (R2)
		rd_idx == REG_TACH2 ? tach2 : // see (R1) (R2)
		rd_idx == REG_PRE1  ? pre1_r : // see (R4)
		rd_idx == REG_PRE2  ? pre2_r : // see (R4)
		rd_idx == REG_DIV   ? div_r : // see (R11)
		rd_idx == REG_IND1  ? ind1_r : // see (R8)
		rd_idx == REG_IND2  ? ind2_r : // see (R8)
		rd_idx == REG_SCAN  ? scan_r : RESET_BYTE; // see (R9) (R10)
	wire rd_take = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_byte};
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Tachometer channels
	fan_tach_chan u_tach1 (
		.clk     (clk),
		.rst_n   (rst_i),
		.tach_in (fan_channel_one),
		.div_sel (div_r[DIV1_LSB +: 2]),
		.preload (pre1_val),
		.restart (pre1_wr),
		.count   (tach1)
	);
	fan_tach_chan u_tach2 (
		.clk     (clk),
		.rst_n   (rst_i),
		.tach_in (fan_channel_two),
		.div_sel (div_r[DIV2_LSB +: 2]),
		.preload (pre2_val),
		.restart (pre2_wr),
		.count   (tach2)
	);

	// Half-second timebase and four-phase blink sequence
	wire half_tick = half_cnt_r == 32'(HALF_SEC_TICKS - 1);
	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			half_cnt_r <= 32'h0000_0000;
			phase_r    <= 2'h0;
		end else begin
			half_cnt_r <= half_tick ? 32'h0000_0000 : half_cnt_r + 32'h1; // see (R13)
			if (half_tick) phase_r <= phase_r + 2'h1;
		end
	end

	function automatic logic led_level(input logic [1:0] code,
		input logic [1:0] ph);
		unique case (led_mode_t'(code))
			LED_OFF:  led_level = 1'b0; // see (R8)
			LED_FAST: led_level = !ph[0]; // see (R6)
			LED_SLOW: led_level = ph == 2'h0; // see (R7)
			LED_ON:   led_level = 1'b1; // see (R8)
		endcase
	endfunction : led_level

	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			indicator_one <= 1'b0;
			indicator_two <= 1'b0;
		end else begin
			indicator_one <= led_level(ind1_r[1:0], phase_r);
			indicator_two <= led_level(ind2_r[1:0], phase_r);
		end
	end

	property p_fast_blink;
		@(posedge clk) disable iff (!rst_i)
		ind1_r[1:0] == LED_FAST && $past(ind1_r[1:0]) == LED_FAST
		|-> indicator_one == !$past(phase_r[0]);
	endproperty
	a_fast_blink: assert property (p_fast_blink) // see (R6)
		else $error("fast blink level wrong");
	property p_slow_blink;
		@(posedge clk) disable iff (!rst_i)
		ind2_r[1:0] == LED_SLOW && $past(ind2_r[1:0]) == LED_SLOW
		|-> indicator_two == ($past(phase_r) == 2'h0);
	endproperty
	a_slow_blink: assert property (p_slow_blink) // see (R7)
		else $error("slow blink level wrong");
	property p_led_off;
		@(posedge clk) disable iff (!rst_i)
		ind1_r[1:0] == LED_OFF ##1 ind1_r[1:0] == LED_OFF |-> !indicator_one;
	endproperty
	a_led_off: assert property (p_led_off) // see (R8)
		else $error("led not off");
	property p_zero_read;
		@(posedge clk) disable iff (!rst_i)
		rd_take && rd_idx > REG_SCAN |=> s_axi_rdata == 32'h0000_0000;
	endproperty
	a_zero_read: assert property (p_zero_read) // see (R10)
		else $error("reserved read not zero");
endmodule : fan_tach_led_runtime

module fan_tach_chan
	import fan_led_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tach_in,
	input  wire logic [1:0] div_sel,
	input  wire logic [7:0] preload,
	input  wire logic       restart,
	output var  logic [7:0] count
);
	logic [2:0] pre_r;
	logic [7:0] run_r;
	logic       tach_d_r;
	wire        edge_seen = tach_in && !tach_d_r;
	wire [2:0]  div_top = div_sel[0] || div_sel[1] ? DIV8_TOP : DIV4_TOP; // see (R11)
	wire        tick = pre_r == div_top;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r    <= 3'h0;
			run_r    <= RESET_BYTE;
			count    <= RESET_BYTE;
			tach_d_r <= 1'b0;
		end else begin
			tach_d_r <= tach_in;
			pre_r    <= (tick || edge_seen || restart) ? 3'h0 : pre_r + 3'h1;
			if (restart) begin
				run_r <= preload; // see (R5)
			end else if (edge_seen) begin
				count <= run_r; // see (R2) (R12)
				run_r <= preload; // see (R12)
			end else if (tick && run_r != COUNT_MAX) begin
				run_r <= run_r + 8'h01; // see (R1)
			end
		end
	end

	property p_latch;
		@(posedge clk) disable iff (!rst_n)
		edge_seen && !restart |=> count == $past(run_r);
	endproperty
	a_latch: assert property (p_latch) // see (R2) (R12)
		else $error("count not latched");
	property p_restart;
		@(posedge clk) disable iff (!rst_n)
		restart |=> run_r == $past(preload);
	endproperty
	a_restart: assert property (p_restart) // see (R5)
		else $error("restart did not reload");
	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		!edge_seen |=> $stable(count);
	endproperty
	a_hold: assert property (p_hold) // see (R2)
		else $error("count changed without pulse");
endmodule : fan_tach_chan
`default_nettype wire

/* tb/fan_led_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module fan_led_partner (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] per_one,
	input  wire logic [15:0] per_two,
	input  wire logic        indicator_one,
	input  wire logic        indicator_two,
	input  wire logic        clear,
	output var  logic        fan_one,
	output var  logic        fan_two,
	output var  int          on_one,
	output var  int          on_two
);
	logic [15:0] c1_r;
	logic [15:0] c2_r;
	// Fan high for half its period; period 0 holds it low
	assign fan_one = (per_one != 16'h0) && (c1_r < (per_one >> 1));
	assign fan_two = (per_two != 16'h0) && (c2_r < (per_two >> 1));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c1_r <= 16'h0;
			c2_r <= 16'h0;
		end else begin
			c1_r <= (c1_r + 16'h1 >= per_one) ? 16'h0 : c1_r + 16'h1;
			c2_r <= (c2_r + 16'h1 >= per_two) ? 16'h0 : c2_r + 16'h1;
		end
	end
	// Lit cycles of each LED since the last clear
	always_ff @(posedge clk) begin
		on_one <= clear ? 0 : on_one + int'(indicator_one);
		on_two <= clear ? 0 : on_two + int'(indicator_two);
	end
endmodule : fan_led_partner
`default_nettype wire

/* tb/fan_tach_led_runtime_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module fan_tach_led_runtime_tb
	import fan_led_pkg::*;
;
	logic        clk = 1'b0;
	logic [3:0]  ws = 4'hF;
	logic        rst_n = 1'b0;
	logic [31:0] aw = 32'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] ar = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic        clr = 1'b0;
	logic [15:0] p1 = 16'h0;
	logic [15:0] p2 = 16'h0;
	logic        awr, wr, bv, arr, rv, f1, f2, l1, l2;
	logic [1:0]  bresp, rresp;
	logic [31:0] rd;
	logic [7:0]  v;
	int          on1, on2;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          tbl[4] = '{0, 32, 16, 64};
	always #2 clk = ~clk;
	fan_tach_led_runtime #(.HALF_SEC_TICKS(8)) dut (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .fan_channel_one(f1),
		.fan_channel_two(f2), .indicator_one(l1), .indicator_two(l2));
	fan_led_partner far (.clk(clk), .rst_n(rst_n), .per_one(p1),
		.per_two(p2), .indicator_one(l1), .indicator_two(l2), .clear(clr),
		.fan_one(f1), .fan_two(f2), .on_one(on1), .on_two(on2));
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic check(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic wr_reg(input logic [31:0] a, d, input logic [1:0] er);
		@(posedge clk);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (bv !== 1'b1);
		br <= 1'b0;
		check("bresp", bresp, er);
	endtask : wr_reg
	task automatic rd_reg(input logic [31:0] a);
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end while (rv !== 1'b1);
		rr <= 1'b0;
		v = rd[7:0];
		check("rresp", rresp, RESP_OKAY);
	endtask : rd_reg
	task automatic rchk(input string n, input logic [31:0] a, e);
		rd_reg(a);
		check(n, v, e);
	endtask : rchk
	task automatic near(input string n, input logic [31:0] a,
		input logic [7:0] e);
		rd_reg(a);
		check(n, (v >= e - 8'h02 && v <= e + 8'h02) ? e : v, e);
	endtask : near
	task automatic led(input int c);
		wr_reg(32'h174, c, RESP_OKAY);
		wr_reg(32'h178, 3 - c, RESP_OKAY);
		repeat (4) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (64) @(posedge clk);
		#1;
		check("led_one", on1, tbl[c]);
		check("led_two", on2, tbl[3 - c]);
	endtask : led
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			end_sim;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("div", 32'h160, DIV_RESET);
		for (int i = 1; i < 8; i++)
			rchk("reset", 32'h160 + 4 * i, RESET_BYTE);
		rchk("rsvd", 32'h180, 8'h00);
		rchk("rsvd", 32'h1FC, 8'h00);
		wr_reg(32'h180, 32'hFF, RESP_SLVERR);
		wr_reg(32'h17C, 32'hA5, RESP_OKAY);
		rchk("scan", 32'h17C, 8'hA5);
		ws <= 4'h0;
		wr_reg(32'h17C, 32'h5A, RESP_OKAY);
		ws <= 4'hF;
		rchk("scan_kept", 32'h17C, 8'hA5);
		wr_reg(32'h174, 32'hFF, RESP_OKAY);
		rchk("led_bits", 32'h174, 8'h03);
		for (int c = 0; c < 4; c++)
			led(c);
		wr_reg(32'h160, 32'h00, RESP_OKAY);
		wr_reg(32'h16C, 32'h10, RESP_OKAY);
		wr_reg(32'h170, 32'h20, RESP_OKAY);
		rchk("pre_one", 32'h16C, 8'h10);
		p1 <= 16'h0320;
		p2 <= 16'h0190;
		repeat (2400) @(posedge clk);
		near("tach_one", 32'h164, 8'hD8);
		near("tach_two", 32'h168, 8'h84);
		wr_reg(32'h160, 32'hF0, RESP_OKAY);
		repeat (2400) @(posedge clk);
		near("tach_one", 32'h164, 8'h74);
		near("tach_two", 32'h168, 8'h52);
		wr_reg(32'h170, 32'hF0, RESP_OKAY);
		p1 <= 16'h0;
		repeat (2400) @(posedge clk);
		rchk("tach_sat", 32'h168, 8'hFF);
		near("tach_held", 32'h164, 8'h74);
		wr_reg(32'h160, 32'h90, RESP_OKAY);
		wr_reg(32'h170, 32'h20, RESP_OKAY);
		p1 <= 16'h0320;
		repeat (2400) @(posedge clk);
		near("tach_div01", 32'h164, 8'h74);
		near("tach_div10", 32'h168, 8'h52);
		end_sim;
	end
endmodule : fan_tach_led_runtime_tb
`default_nettype wire
